// *** verilog/i2c_reg_map.svh ***
// Purpose: shared constants of the register-access I2C link, both ends
// Assumes: 25 MHz clk_sys on both ends
// Notes: byte-addressed register image of 128 bytes
`ifndef I2C_REG_MAP_SVH
`define I2C_REG_MAP_SVH

`define REG_BYTES 128
`define DEV_ADDR_DFLT 7'h37
`define ADDR_MIN 7'h08
`define ADDR_MAX 7'h77
`define CFG_ADDR_OFS 7'h51
`define DUMMY_OFS 8'h00
`define DUMMY_WRITES 2
`define CLK_PERIOD_NS 40
`define WAKE_NS 20000
`define WAKE_CYCLES ((`WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SCL_HALF_NS 5000
`define SCL_HALF_CYCLES (`SCL_HALF_NS / `CLK_PERIOD_NS)
`define BIT_ACK 4'h8

`endif

// *** verilog/i2c_reg_pkg.sv ***
// Purpose: types shared by both ends of the register-access link
// Assumes: nothing
// Notes: one-hot state codes
`default_nettype none
package i2c_reg_pkg;
    typedef enum logic [5:0] {
        T_IDLE = 6'h01,
        T_ADDR = 6'h02,
        T_ACKA = 6'h04,
        T_WR = 6'h08,
        T_ACKW = 6'h10,
        T_RD = 6'h20
    } tgt_state_t;
    typedef enum logic [3:0] {
        H_IDLE = 4'h1,
        H_START = 4'h2,
        H_BIT = 4'h4,
        H_STOP = 4'h8
    } host_state_t;
endpackage : i2c_reg_pkg
`default_nettype wire

// *** verilog/i2c_link_if.sv ***
// Purpose: open-drain two-wire link between host and target
// Assumes: pull-ups on both lines
// Notes: a line is low when any party enables a low drive
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_scl_o;
    logic dev_scl_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;
    // wired-and with pull-up
    assign scl = ~((host_scl_oe & ~host_scl_o) | (dev_scl_oe & ~dev_scl_o));
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
    modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, input scl, sda);
    modport target (output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe, input scl, sda);
endinterface : i2c_link_if
`default_nettype wire

// *** verilog/i2c_target.sv ***
// Purpose: register-access I2C target with deep-sleep refusal
// Assumes: link lines are asynchronous, synchronised here
// Notes: refusal by no-ack replaces clock stretching
`timescale 1ns/1ps
`default_nettype none
`include "i2c_reg_map.svh"
module i2c_target #(
    parameter int REG_BYTES = `REG_BYTES,
    parameter int WAKE_CYCLES = `WAKE_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // link
    i2c_link_if.target link,
    // user side
    input wire logic por,
    input wire logic touch_act,
    input wire logic sleep_req,
    output logic asleep,
    output logic [6:0] active_addr,
    output logic wr_stb,
    output logic [6:0] wr_ofs,
    output logic [7:0] wr_byte
);
    i2c_reg_pkg::tgt_state_t st_q, st_d;
    logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
    logic rise, fall, start, stop;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d;
    logic [6:0] ptr_q, ptr_d;
    logic rw_q, rw_d, first_q, first_d, ack_q, ack_d, oe_q, oe_d;
    logic asleep_q, asleep_d, waking_q, waking_d, load_q, load_d;
    logic [15:0] wcnt_q, wcnt_d;
    logic [6:0] act_q, act_d;
    logic stb_q, stb_d;
    logic [6:0] wofs_q, wofs_d;
    logic [7:0] wbyte_q, wbyte_d;
    logic [7:0] mem_q [REG_BYTES];
    logic [7:0] mem_d [REG_BYTES];
    logic nack_evt;
    logic [7:0] cfg_byte;

    // two flip-flops on each line before any logic reads it
    always_ff @(posedge clk_sys) begin
        scl_m_q <= link.scl;
        scl_s_q <= scl_m_q;
        scl_p_q <= scl_s_q;
        sda_m_q <= link.sda;
        sda_s_q <= sda_m_q;
        sda_p_q <= sda_s_q;
    end

    // line events, all from synchronised copies
    assign rise = scl_s_q & ~scl_p_q;
    assign fall = ~scl_s_q & scl_p_q;
    assign start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign stop = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
    assign cfg_byte = mem_q[`CFG_ADDR_OFS];

    // next state of the protocol engine, wake logic and image
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        ptr_d = ptr_q;
        rw_d = rw_q;
        first_d = first_q;
        ack_d = ack_q;
        oe_d = oe_q;
        asleep_d = asleep_q;
        waking_d = waking_q;
        wcnt_d = wcnt_q;
        load_d = 1'b0;
        act_d = act_q;
        stb_d = 1'b0;
        wofs_d = wofs_q;
        wbyte_d = wbyte_q;
        mem_d = mem_q;
        nack_evt = 1'b0;
        // pointer is left alone on stop, so a later read starts there
        if (start) begin
            st_d = i2c_reg_pkg::T_ADDR;
            cnt_d = 4'h0;
            oe_d = 1'b0;
        end else if (stop) begin
            st_d = i2c_reg_pkg::T_IDLE;
            oe_d = 1'b0;
        end else begin
            case (st_q)
                i2c_reg_pkg::T_IDLE: begin
                    oe_d = 1'b0;
                end
                i2c_reg_pkg::T_ADDR: begin
                    if (rise) begin
                        sh_d = {sh_q[6:0], sda_s_q};
                        cnt_d = cnt_q + 4'h1;
                    end else if (fall && cnt_q == `BIT_ACK) begin
                        if (sh_q[7:1] != act_q) begin
                            st_d = i2c_reg_pkg::T_IDLE;
                        end else if (asleep_q) begin
                            // line left released: the host sees a no-ack
                            nack_evt = 1'b1;
                            st_d = i2c_reg_pkg::T_IDLE;
                        end else begin
                            oe_d = 1'b1;
                            rw_d = sh_q[0];
                            first_d = 1'b1;
                            st_d = i2c_reg_pkg::T_ACKA;
                        end
                    end
                end
                i2c_reg_pkg::T_ACKA: begin
                    if (fall) begin
                        cnt_d = 4'h0;
                        if (rw_q) begin
                            sh_d = mem_q[ptr_q];
                            oe_d = ~mem_q[ptr_q][7];
                            st_d = i2c_reg_pkg::T_RD;
                        end else begin
                            oe_d = 1'b0;
                            st_d = i2c_reg_pkg::T_WR;
                        end
                    end
                end
                i2c_reg_pkg::T_WR: begin
                    if (rise) begin
                        sh_d = {sh_q[6:0], sda_s_q};
                        cnt_d = cnt_q + 4'h1;
                    end else if (fall && cnt_q == `BIT_ACK) begin
                        oe_d = 1'b1;
                        st_d = i2c_reg_pkg::T_ACKW;
                        if (first_q) begin
                            // first byte after the address is the offset
                            ptr_d = sh_q[6:0];
                            first_d = 1'b0;
                        end else begin
                            mem_d[ptr_q] = sh_q;
                            stb_d = 1'b1;
                            wofs_d = ptr_q;
                            wbyte_d = sh_q;
                            ptr_d = ptr_q + 7'h01;
                        end
                    end
                end
                i2c_reg_pkg::T_ACKW: begin
                    if (fall) begin
                        oe_d = 1'b0;
                        cnt_d = 4'h0;
                        st_d = i2c_reg_pkg::T_WR;
                    end
                end
                i2c_reg_pkg::T_RD: begin
                    // cnt 0..7 data bits, 8 is the host's ack slot
                    if (rise) begin
                        if (cnt_q == `BIT_ACK) begin
                            ack_d = ~sda_s_q;
                        end
                        cnt_d = cnt_q + 4'h1;
                    end else if (fall) begin
                        if (cnt_q == `BIT_ACK) begin
                            oe_d = 1'b0;
                            ptr_d = ptr_q + 7'h01;
                        end else if (cnt_q > `BIT_ACK) begin
                            if (ack_q) begin
                                sh_d = mem_q[ptr_q];
                                oe_d = ~mem_q[ptr_q][7];
                                cnt_d = 4'h0;
                            end else begin
                                st_d = i2c_reg_pkg::T_IDLE;
                            end
                        end else begin
                            oe_d = ~sh_q[6];
                            sh_d = {sh_q[6:0], 1'b0};
                        end
                    end
                end
                default: begin
                    st_d = i2c_reg_pkg::T_IDLE;
                    oe_d = 1'b0;
                end
            endcase
        end
        // deep sleep: leave on touch or on a refused addressed command
        if (asleep_q && !waking_q && (touch_act || nack_evt)) begin
            waking_d = 1'b1;
            wcnt_d = 16'h0000;
        end else if (waking_q) begin
            if (wcnt_q == 16'(WAKE_CYCLES - 1)) begin
                waking_d = 1'b0;
                asleep_d = 1'b0;
            end else begin
                wcnt_d = wcnt_q + 16'h0001;
            end
        end else if (!asleep_q && sleep_req && st_q == i2c_reg_pkg::T_IDLE) begin
            asleep_d = 1'b1;
        end
        // image takes effect once, right after reset release
        if (load_q) begin
            if (cfg_byte[6:0] >= `ADDR_MIN && cfg_byte[6:0] <= `ADDR_MAX
                    && cfg_byte[7] == 1'b0) begin
                act_d = cfg_byte[6:0];
            end else begin
                act_d = `DEV_ADDR_DFLT;
            end
        end
        // power-on clears the image, an ordinary reset keeps it
        if (por) begin
            for (int i = 0; i < REG_BYTES; i++) begin
                mem_d[i] = 8'h00;
            end
        end
    end

    // state registers; the image is not touched by srst
    always_ff @(posedge clk_sys) begin
        mem_q <= mem_d;
        if (srst) begin
            st_q <= i2c_reg_pkg::T_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 7'h00;
            rw_q <= 1'b0;
            first_q <= 1'b0;
            ack_q <= 1'b0;
            oe_q <= 1'b0;
            asleep_q <= 1'b1;
            waking_q <= 1'b0;
            wcnt_q <= 16'h0000;
            load_q <= 1'b1;
            act_q <= `DEV_ADDR_DFLT;
            stb_q <= 1'b0;
            wofs_q <= 7'h00;
            wbyte_q <= 8'h00;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            ptr_q <= ptr_d;
            rw_q <= rw_d;
            first_q <= first_d;
            ack_q <= ack_d;
            oe_q <= oe_d;
            asleep_q <= asleep_d;
            waking_q <= waking_d;
            wcnt_q <= wcnt_d;
            load_q <= load_d;
            act_q <= act_d;
            stb_q <= stb_d;
            wofs_q <= wofs_d;
            wbyte_q <= wbyte_d;
        end
    end

    // the clock line is never driven: no stretching, even while waking
    assign link.dev_scl_oe = 1'b0;
    assign link.dev_scl_o = 1'b0;
    assign link.dev_sda_o = 1'b0;
    assign link.dev_sda_oe = oe_q;
    assign asleep = asleep_q;
    assign active_addr = act_q;
    assign wr_stb = stb_q;
    assign wr_ofs = wofs_q;
    assign wr_byte = wbyte_q;
endmodule : i2c_target
`default_nettype wire

// *** verilog/i2c_host.sv ***
// Purpose: host end: dummy writes, offset write, data write or read
// Assumes: target never stretches the clock
// Notes: a refused main transfer is repeated whole until acknowledged
`timescale 1ns/1ps
`default_nettype none
`include "i2c_reg_map.svh"
module i2c_host #(
    parameter int HALF_CYCLES = `SCL_HALF_CYCLES,
    parameter int DUMMY_WRITES = `DUMMY_WRITES,
    parameter logic [6:0] TGT_ADDR = `DEV_ADDR_DFLT
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // link
    i2c_link_if.host link,
    // command
    input wire logic cmd_valid,
    input wire logic cmd_read,
    input wire logic [7:0] cmd_ofs,
    input wire logic [7:0] cmd_len,
    output logic cmd_ready,
    // write data, indexed
    output logic [7:0] wr_idx,
    input wire logic [7:0] wr_byte,
    // read data and completion
    output logic rd_stb,
    output logic [7:0] rd_byte,
    output logic done
);
    localparam logic [2:0] PH_WR = 3'(DUMMY_WRITES);
    localparam logic [2:0] PH_RD = 3'(DUMMY_WRITES + 1);
    i2c_reg_pkg::host_state_t st_q, st_d;
    logic sda_m_q, sda_s_q;
    logic [15:0] div_q, div_d;
    logic [1:0] half_q, half_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] byte_q, byte_d, sh_q, sh_d, len_q, len_d, ofs_q, ofs_d, idx_q, idx_d;
    logic [7:0] rdb_q, rdb_d, tx;
    logic [2:0] ph_q, ph_d;
    logic rd_q, rd_d, fin_q, fin_d, scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
    logic rstb_q, rstb_d, done_q, done_d, rdy_q, rdy_d, tick, last, rdata;

    // data line passes two flip-flops
    always_ff @(posedge clk_sys) begin
        sda_m_q <= link.sda;
        sda_s_q <= sda_m_q;
    end

    assign tick = (div_q == 16'(HALF_CYCLES - 1));
    assign rdata = (ph_q == PH_RD) && (byte_q != 8'h00);
    // byte to send and end of the current transaction
    always_comb begin
        if (byte_q == 8'h00) begin
            tx = {TGT_ADDR, ph_q == PH_RD};
        end else if (ph_q < PH_WR) begin
            tx = `DUMMY_OFS;
        end else if (ph_q == PH_WR && byte_q == 8'h01) begin
            tx = ofs_q;
        end else if (ph_q == PH_WR) begin
            tx = wr_byte;
        end else begin
            tx = 8'hff;
        end
        if (ph_q == PH_RD) begin
            last = (byte_q == len_q);
        end else if (ph_q == PH_WR && !rd_q) begin
            last = (byte_q == len_q + 8'h01);
        end else begin
            last = (byte_q == 8'h01);
        end
    end

    // sequencer, one step per half clock period
    always_comb begin
        st_d = st_q;
        div_d = tick ? 16'h0000 : div_q + 16'h0001;
        half_d = half_q;
        bit_d = bit_q;
        byte_d = byte_q;
        sh_d = sh_q;
        len_d = len_q;
        ofs_d = ofs_q;
        idx_d = byte_q - 8'h02;
        rdb_d = rdb_q;
        ph_d = ph_q;
        rd_d = rd_q;
        fin_d = fin_q;
        scl_oe_d = scl_oe_q;
        sda_oe_d = sda_oe_q;
        rstb_d = 1'b0;
        done_d = 1'b0;
        rdy_d = rdy_q;
        case (st_q)
            i2c_reg_pkg::H_IDLE: begin
                div_d = 16'h0000;
                if (cmd_valid && rdy_q) begin
                    rdy_d = 1'b0;
                    rd_d = cmd_read;
                    ofs_d = cmd_ofs;
                    len_d = cmd_len;
                    ph_d = 3'h0;
                    fin_d = 1'b0;
                    half_d = 2'h0;
                    st_d = i2c_reg_pkg::H_START;
                end
            end
            i2c_reg_pkg::H_START: begin
                if (tick) begin
                    if (half_q == 2'h0) begin
                        scl_oe_d = 1'b0;
                        sda_oe_d = 1'b0;
                        half_d = 2'h1;
                    end else begin
                        sda_oe_d = 1'b1;
                        half_d = 2'h0;
                        bit_d = 4'h0;
                        byte_d = 8'h00;
                        st_d = i2c_reg_pkg::H_BIT;
                    end
                end
            end
            i2c_reg_pkg::H_BIT: begin
                if (tick && half_q == 2'h0) begin
                    scl_oe_d = 1'b1;
                    half_d = 2'h1;
                    if (bit_q == 4'h0) begin
                        sh_d = tx;
                        sda_oe_d = ~tx[7];
                    end else if (bit_q == `BIT_ACK) begin
                        sda_oe_d = rdata && !last;
                    end else begin
                        sda_oe_d = ~sh_q[7];
                    end
                end else if (tick) begin
                    scl_oe_d = 1'b0;
                    half_d = 2'h0;
                    bit_d = bit_q + 4'h1;
                    if (bit_q != `BIT_ACK) begin
                        sh_d = {sh_q[6:0], sda_s_q};
                    end else begin
                        bit_d = 4'h0;
                        byte_d = byte_q + 8'h01;
                        if (rdata) begin
                            rstb_d = 1'b1;
                            rdb_d = sh_q;
                        end
                        if (!rdata && sda_s_q) begin
                            // refused: dummies move on, real transfers repeat
                            st_d = i2c_reg_pkg::H_STOP;
                            if (ph_q < PH_WR) begin
                                ph_d = ph_q + 3'h1;
                            end
                        end else if (last) begin
                            st_d = i2c_reg_pkg::H_STOP;
                            if (ph_q < PH_WR || (ph_q == PH_WR && rd_q)) begin
                                ph_d = ph_q + 3'h1;
                            end else begin
                                fin_d = 1'b1;
                            end
                        end
                    end
                end
            end
            i2c_reg_pkg::H_STOP: begin
                if (tick) begin
                    half_d = half_q + 2'h1;
                    if (half_q == 2'h0) begin
                        scl_oe_d = 1'b1;
                        sda_oe_d = 1'b1;
                    end else if (half_q == 2'h1) begin
                        scl_oe_d = 1'b0;
                    end else begin
                        sda_oe_d = 1'b0;
                        half_d = 2'h0;
                        if (fin_q) begin
                            done_d = 1'b1;
                            rdy_d = 1'b1;
                            st_d = i2c_reg_pkg::H_IDLE;
                        end else begin
                            st_d = i2c_reg_pkg::H_START;
                        end
                    end
                end
            end
            default: begin
                st_d = i2c_reg_pkg::H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_q <= i2c_reg_pkg::H_IDLE;
            div_q <= 16'h0000;
            half_q <= 2'h0;
            bit_q <= 4'h0;
            byte_q <= 8'h00;
            sh_q <= 8'h00;
            len_q <= 8'h00;
            ofs_q <= 8'h00;
            idx_q <= 8'h00;
            rdb_q <= 8'h00;
            ph_q <= 3'h0;
            rd_q <= 1'b0;
            fin_q <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            rstb_q <= 1'b0;
            done_q <= 1'b0;
            rdy_q <= 1'b1;
        end else begin
            st_q <= st_d;
            div_q <= div_d;
            half_q <= half_d;
            bit_q <= bit_d;
            byte_q <= byte_d;
            sh_q <= sh_d;
            len_q <= len_d;
            ofs_q <= ofs_d;
            idx_q <= idx_d;
            rdb_q <= rdb_d;
            ph_q <= ph_d;
            rd_q <= rd_d;
            fin_q <= fin_d;
            scl_oe_q <= scl_oe_d;
            sda_oe_q <= sda_oe_d;
            rstb_q <= rstb_d;
            done_q <= done_d;
            rdy_q <= rdy_d;
        end
    end

    assign link.host_scl_o = 1'b0;
    assign link.host_sda_o = 1'b0;
    assign link.host_scl_oe = scl_oe_q;
    assign link.host_sda_oe = sda_oe_q;
    assign cmd_ready = rdy_q;
    assign wr_idx = idx_q;
    assign rd_stb = rstb_q;
    assign rd_byte = rdb_q;
    assign done = done_q;
endmodule : i2c_host
`default_nettype wire

// *** verif/i2c_link_checker.sv ***
// Purpose: wire-level checks on the two-wire link between both ends
// Assumes: host built with HALF_CYCLES of 8
// Notes: sees link signals only, so the user-side rules are judged by tb
`timescale 1ns/1ps
`default_nettype none
module i2c_link_checker (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // host drives
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic host_scl_oe,
    // target drives
    input wire logic dev_scl_oe,
    input wire logic dev_sda_oe,
    // resolved lines
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    // start: data pulled low while the clock is high, then the clock follows
    sequence start_seq;
        $rose(host_sda_oe) && scl;
    endsequence
    sequence clock_low_seq;
        ##[1:10] !scl;
    endsequence
    // target edges only while the clock is low, so no false start or stop
    AST_NO_STRETCH: assert property (dev_scl_oe == 1'b0) else $error("clock held by target");
    AST_IDLE_RESET: assert property ($fell(srst) |-> scl && sda) else $error("lines not idle");
    AST_START_CLOCK: assert property (start_seq |-> clock_low_seq) else $error("no clock");
    AST_STOP_IDLE: assert property ($fell(host_sda_oe) && scl |-> sda [*8]) else $error("stop");
    AST_DEV_SET_LOW: assert property ($rose(dev_sda_oe) |-> !scl) else $error("drive on high");
    AST_DEV_FREE_LOW: assert property ($fell(dev_sda_oe) |-> !scl) else $error("free on high");
    AST_ACK_HOLD: assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*8]) else $error("ack short");
    AST_HOST_OD: assert property (host_sda_oe |-> !host_sda_o) else $error("host drove high");
    AST_SCL_STEP: assert property ($fell(host_scl_oe) |-> !host_scl_oe [*8]) else $error("step");
    cover property (start_seq);
endmodule : i2c_link_checker
`default_nettype wire

// *** verif/tb.sv ***
// Purpose: host and target joined back to back, checked at user sides
// Assumes: short wake and bit times for a quick run
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic por = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_read = 1'b0;
    logic [7:0] cmd_ofs = 8'h00;
    logic [7:0] cmd_len = 8'h00;
    logic touch_act = 1'b0;
    logic sleep_req = 1'b0;
    logic cmd_ready, rd_stb, done, asleep, wr_stb;
    logic [7:0] wr_idx, rd_byte, wr_data, tgt_byte;
    logic [6:0] active_addr, wr_ofs;
    logic [7:0] wbuf [4] = '{default: 8'h00};
    logic [14:0] stored [$];
    logic [14:0] rdq [$];
    int error_cnt = 0;
    int checks = 0;
    always #20 clk_sys = ~clk_sys;
    // host re-reads the buffer on every retry
    assign wr_data = wbuf[wr_idx[1:0]];
    i2c_link_if i2c_link_if_inst ();
    i2c_host #(.HALF_CYCLES(8)) i2c_host_inst (.clk_sys(clk_sys), .srst(srst),
        .link(i2c_link_if_inst), .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_ofs(cmd_ofs),
        .cmd_len(cmd_len), .cmd_ready(cmd_ready), .wr_idx(wr_idx), .wr_byte(wr_data),
        .rd_stb(rd_stb), .rd_byte(rd_byte), .done(done));
    i2c_target #(.WAKE_CYCLES(20)) i2c_target_inst (.clk_sys(clk_sys), .srst(srst),
        .link(i2c_link_if_inst), .por(por), .touch_act(touch_act), .sleep_req(sleep_req),
        .asleep(asleep), .active_addr(active_addr), .wr_stb(wr_stb), .wr_ofs(wr_ofs),
        .wr_byte(tgt_byte));
    i2c_link_checker i2c_link_checker_inst (.clk_sys(clk_sys), .srst(srst),
        .host_sda_o(i2c_link_if_inst.host_sda_o), .host_sda_oe(i2c_link_if_inst.host_sda_oe),
        .host_scl_oe(i2c_link_if_inst.host_scl_oe), .dev_scl_oe(i2c_link_if_inst.dev_scl_oe),
        .dev_sda_oe(i2c_link_if_inst.dev_sda_oe), .scl(i2c_link_if_inst.scl),
        .sda(i2c_link_if_inst.sda));
    // collect stored and read bytes as they pass
    always @(posedge clk_sys) begin
        if (wr_stb === 1'b1) stored.push_back({wr_ofs, tgt_byte});
        if (rd_stb === 1'b1) rdq.push_back({7'h00, rd_byte});
    end
    task automatic cmp_val(input string name, input logic [14:0] exp, input logic [14:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp_val
    task automatic end_of_test();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test
    // one whole host command; a hung link is cut short by the bound
    task automatic run_cmd(input logic rd, input logic [7:0] ofs, input logic [7:0] len);
        int n;
        n = 0;
        cmp_val("cmd_ready", 15'h0001, {14'h0000, cmd_ready});
        cmd_read = rd;
        cmd_ofs = ofs;
        cmd_len = len;
        cmd_valid = 1'b1;
        @(posedge clk_sys);
        #1 cmd_valid = 1'b0;
        while (done !== 1'b1 && n < 20000) begin
            @(posedge clk_sys);
            #1 n++;
        end
        cmp_val("done", 15'h0001, {14'h0000, done});
        @(posedge clk_sys);
        #1;
    endtask : run_cmd
    task automatic t_reset();
        cmp_val("asleep", 15'h0001, {14'h0000, asleep});
        cmp_val("active_addr", 15'h0037, {8'h00, active_addr});
    endtask : t_reset
    // first write while asleep: refusals and dummies must still land all bytes
    task automatic t_write();
        wbuf = '{8'ha1, 8'hb2, 8'hc3, 8'h00};
        stored.delete();
        run_cmd(1'b0, 8'h10, 8'h03);
        cmp_val("asleep", 15'h0000, {14'h0000, asleep});
        cmp_val("count", 15'h0003, 15'(stored.size()));
        for (int i = 0; i < 3; i++) begin
            cmp_val("stored", {7'h10 + 7'(i), wbuf[i]}, stored[i]);
        end
    endtask : t_write
    // pointer set by an offset-only write, then read in a later transaction
    task automatic t_read();
        stored.delete();
        rdq.delete();
        run_cmd(1'b1, 8'h11, 8'h02);
        cmp_val("rd0", 15'h00b2, rdq[0]);
        cmp_val("rd1", 15'h00c3, rdq[1]);
        cmp_val("rd_count", 15'h0002, 15'(rdq.size()));
        cmp_val("no_store", 15'h0000, 15'(stored.size()));
    endtask : t_read
    // sleep on request while idle, then a touch wakes after the wake time of 20 cycles
    task automatic t_sleep();
        sleep_req = 1'b1;
        @(posedge clk_sys);
        #1 sleep_req = 1'b0;
        cmp_val("slept", 15'h0001, {14'h0000, asleep});
        touch_act = 1'b1;
        @(posedge clk_sys);
        #1 touch_act = 1'b0;
        repeat (19) @(posedge clk_sys);
        #1;
        cmp_val("still_waking", 15'h0001, {14'h0000, asleep});
        @(posedge clk_sys);
        #1;
        cmp_val("awake", 15'h0000, {14'h0000, asleep});
    endtask : t_sleep
    // lowest legal address loaded only at the next reset
    task automatic t_cfg();
        wbuf[0] = 8'h08;
        run_cmd(1'b0, 8'h51, 8'h01);
        cmp_val("addr_kept", 15'h0037, {8'h00, active_addr});
        srst = 1'b1;
        @(posedge clk_sys);
        #1 srst = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        cmp_val("addr_new", 15'h0008, {8'h00, active_addr});
        cmp_val("asleep", 15'h0001, {14'h0000, asleep});
    endtask : t_cfg
    initial begin
        repeat (10) @(posedge clk_sys);
        #1 srst = 1'b0;
        por = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        t_reset();
        t_write();
        t_read();
        t_sleep();
        t_cfg();
        end_of_test();
    end
    // watchdog well beyond the few thousand cycles the commands need
    initial begin
        #1000000;
        error_cnt++;
        end_of_test();
    end
endmodule : tb
`default_nettype wire
